// ==== design/scp_serial_port.sv ====
`timescale 1ns/1ps
module scp_serial_port (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_spi_clk,
  input wire logic i_spi_cs_n,
  input wire logic i_three_wire,
  input wire logic i_serial_in,
  input wire logic i_sdio_in,
  output logic o_sdio_out,
  output logic o_sdio_oe,
  output logic o_serial_out_pin,
  output logic o_serial_out_oe,
  input wire logic [10:0] i_cfg_rd_addr,
  output logic [7:0] o_cfg_rd_data,
  output logic o_cfg_wr,
  output scp_pkg::scp_wr_t o_cfg_wr_word
);

  // ==========================================================
  // Link side: frame reset and data input
  logic link_rst_n;
  logic din;
  logic mode_m1_r;
  logic mode_m2_r;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic [22:0] sh_r;
  logic [23:0] sh_nxt;
  scp_pkg::scp_hdr_t hdr_r;
  scp_pkg::scp_hdr_t hdr_nxt;
  logic [7:0] rd_byte_r;
  scp_pkg::scp_wr_t hold_r;
  logic tgl_r;
  logic frame_done;
  logic addr_done;
  logic out_en;
  logic [2:0] out_idx;
  logic [7:0] mem [scp_pkg::REG_DEPTH];

  // Select high holds the frame shifter and read output in reset
  assign link_rst_n = i_rst_n & ~i_spi_cs_n;

  // Data input follows the wiring mode
  assign din = mode_m2_r ? i_sdio_in : i_serial_in;

  assign sh_nxt = {sh_r, din};

  // Count saturates at a full frame
  assign cnt_nxt = (cnt_r == scp_pkg::CNT_FRAME_DONE) ? cnt_r :
                   cnt_r + 5'h01;

  // Header taken from the first five bits
  assign hdr_nxt = (cnt_nxt == scp_pkg::CNT_HDR_DONE) ?
                   scp_pkg::scp_hdr_t'(sh_nxt[4:0]) : hdr_r;

  assign addr_done = (cnt_nxt == scp_pkg::CNT_ADDR_DONE) &&
                     (cnt_r != scp_pkg::CNT_ADDR_DONE);
  assign frame_done = (cnt_nxt == scp_pkg::CNT_FRAME_DONE) &&
                      (cnt_r != scp_pkg::CNT_FRAME_DONE);

  // Read byte window covers bits 17 to 24
  assign out_en = hdr_r.rd && (cnt_r >= scp_pkg::CNT_ADDR_DONE) &&
                  (cnt_r < scp_pkg::CNT_FRAME_DONE);
  assign out_idx = 3'(5'h17 - cnt_r);

  // ==========================================================
  // Link side: mode strap synchroniser
  always_ff @(posedge i_spi_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_m1_r <= 1'b0;
      mode_m2_r <= 1'b0;
    end else begin
      mode_m1_r <= i_three_wire;
      mode_m2_r <= mode_m1_r;
    end
  end

  // ==========================================================
  // Link side: frame shifter
  always_ff @(posedge i_spi_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cnt_r <= 5'h00;
      sh_r <= 23'h000000;
      hdr_r <= '0;
      rd_byte_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt[22:0];
      hdr_r <= hdr_nxt;
      // Address completes at bit 16, fetch byte
      if (addr_done) begin
        rd_byte_r <= mem[sh_nxt[10:0]];
      end
    end
  end

  // ==========================================================
  // Link side: write hand-off, survives select rise
  always_ff @(posedge i_spi_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold_r <= '0;
      tgl_r <= 1'b0;
    end else begin
      // Only a complete write frame is passed on
      if (frame_done && !hdr_r.rd) begin
        hold_r <= scp_pkg::scp_wr_t'(sh_nxt[18:0]);
        tgl_r <= ~tgl_r;
      end
    end
  end

  // ==========================================================
  // Link side: read data launched on falling edge
  always_ff @(negedge i_spi_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      o_sdio_out <= 1'b0;
      o_sdio_oe <= 1'b0;
      o_serial_out_pin <= 1'b0;
      o_serial_out_oe <= 1'b0;
    end else begin
      // Three-wire drives the data pin, then releases
      o_sdio_out <= out_en && mode_m2_r && rd_byte_r[out_idx];
      o_sdio_oe <= out_en && mode_m2_r;
      o_serial_out_pin <= out_en && !mode_m2_r && rd_byte_r[out_idx];
      o_serial_out_oe <= out_en && !mode_m2_r;
    end
  end

  // ==========================================================
  // System side: toggle synchroniser
  logic tgl_s1_r;
  logic tgl_s2_r;
  logic tgl_s3_r;
  logic wr_evt;

  assign wr_evt = tgl_s2_r ^ tgl_s3_r;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
    end else begin
      tgl_s1_r <= tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
    end
  end

  // ==========================================================
  // System side: control byte store
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < scp_pkg::REG_DEPTH; i++) begin
        mem[i] <= scp_pkg::REG_RST;
      end
    end else begin
      // Data byte stored at the frame address
      if (wr_evt) begin
        mem[hold_r.addr] <= hold_r.data;
      end
    end
  end

  // ==========================================================
  // System side: device view of the control bytes
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cfg_wr <= 1'b0;
      o_cfg_wr_word <= '0;
      o_cfg_rd_data <= scp_pkg::REG_RST;
    end else begin
      // Each write reported to the device logic
      o_cfg_wr <= wr_evt;
      if (wr_evt) begin
        o_cfg_wr_word <= hold_r;
      end
      o_cfg_rd_data <= mem[i_cfg_rd_addr];
    end
  end

endmodule

// ==== design/scp_pkg.sv ====
package scp_pkg;

  // ==========================================================
  // Frame layout
  localparam int unsigned FRAME_W = 24;
  localparam int unsigned HDR_W = 5;
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned REG_DEPTH = 2048;

  // Bit counts at which each field is complete
  localparam logic [4:0] CNT_HDR_DONE = 5'h05;
  localparam logic [4:0] CNT_ADDR_DONE = 5'h10;
  localparam logic [4:0] CNT_FRAME_DONE = 5'h18;

  // Header field positions inside the header
  localparam int unsigned HDR_RD_POS = 4;

  // Field positions inside the whole frame
  localparam int unsigned FR_ADDR_LSB = 8;
  localparam int unsigned FR_HDR_LSB = 19;

  // Reset values
  localparam logic [7:0] REG_RST = 8'h00;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic rd;
    logic [3:0] nbytes;
  } scp_hdr_t;

  typedef struct packed {
    logic [10:0] addr;
    logic [7:0] data;
  } scp_wr_t;

endpackage

// ==== bench/scp_props.sv ====
`timescale 1ns/1ps
module scp_props (
  input wire logic i_sys_clk, i_rst_n, i_spi_clk, i_spi_cs_n, i_three_wire,
  input wire logic i_serial_in, i_sdio_in, o_sdio_out, o_sdio_oe,
  input wire logic o_serial_out_pin, o_serial_out_oe, o_cfg_wr,
  input wire logic [10:0] i_cfg_rd_addr,
  input wire logic [7:0] o_cfg_rd_data,
  input wire scp_pkg::scp_wr_t o_cfg_wr_word
);
  // ========
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_byte; (o_sdio_oe || o_serial_out_oe)[*8]; endsequence
  property p_oe_len;
    @(negedge i_spi_clk) disable iff (!i_rst_n || i_spi_cs_n)
    $rose(o_sdio_oe || o_serial_out_oe) |-> s_byte;
  endproperty
  a_oe_len: assert property (p_oe_len) else $error("len");
  property p_wr; o_cfg_wr |=> !o_cfg_wr; endproperty
  a_wr: assert property (p_wr) else $error("pulse");
  property p_hold; $changed(o_cfg_wr_word) |-> o_cfg_wr; endproperty
  a_hold: assert property (p_hold) else $error("word");
  property p_excl; !(o_sdio_oe && o_serial_out_oe); endproperty
  a_excl: assert property (p_excl) else $error("both");
  property p_rel; i_spi_cs_n |-> !o_sdio_oe && !o_serial_out_oe; endproperty
  a_rel: assert property (p_rel) else $error("rel");
  property p_4w; i_three_wire |-> !o_serial_out_oe; endproperty
  a_4w: assert property (p_4w) else $error("4w");
  property p_3w; !i_three_wire |-> !o_sdio_oe; endproperty
  a_3w: assert property (p_3w) else $error("3w");
  property p_idle; !o_serial_out_oe |-> !o_serial_out_pin; endproperty
  a_idle: assert property (p_idle) else $error("idle");
endmodule
bind scp_serial_port scp_props i_scp_props (.*);

// ==== bench/scp_host.sv ====
`timescale 1ns/1ps
module scp_host (
  input wire logic i_tw, i_dev_d, i_dev_oe, i_sout,
  output logic o_clk, o_cs_n, o_ser, o_sdio
);
  logic h_d = 1'b0;
  logic h_oe = 1'b1;
  assign o_sdio = i_dev_oe ? i_dev_d : (h_oe ? h_d : ~h_d);
  assign o_ser = h_oe ? h_d : ~h_d;
  initial begin
    o_clk = 1'b0;
    o_cs_n = 1'b1;
  end
  task automatic frame(input logic rd, input logic [10:0] a,
      input logic [7:0] d, input int n, output logic [7:0] q);
    logic [23:0] f;
    f = {rd, 4'h1, a, d};
    q = 8'h00;
    repeat (2) begin
      #62.5 o_clk = 1'b1;
      #62.5 o_clk = 1'b0;
    end
    #1.3 o_cs_n = 1'b0;
    for (int i = 23; i > 23 - n; i--) begin
      h_oe = !(rd && i < 8);
      h_d = f[i];
      #62.5 o_clk = 1'b1;
      if (i < 8) q[i] = i_tw ? o_sdio : i_sout;
      #62.5 o_clk = 1'b0;
    end
    #62.5 o_cs_n = 1'b1;
    h_oe = 1'b1;
    #250;
  endtask
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic i_sys_clk, i_rst_n, i_three_wire;
  logic [10:0] i_cfg_rd_addr;
  logic i_spi_clk, i_spi_cs_n, i_serial_in, i_sdio_in;
  logic o_sdio_out, o_sdio_oe, o_serial_out_pin, o_serial_out_oe, o_cfg_wr;
  logic [7:0] o_cfg_rd_data, q;
  scp_pkg::scp_wr_t o_cfg_wr_word;
  int error_cnt = 0;
  int n_checks = 0;
  int wr_cnt = 0;
  scp_host i_scp_host (.i_tw(i_three_wire), .i_dev_d(o_sdio_out),
    .i_dev_oe(o_sdio_oe), .i_sout(o_serial_out_pin), .o_clk(i_spi_clk),
    .o_cs_n(i_spi_cs_n), .o_ser(i_serial_in), .o_sdio(i_sdio_in));
  scp_serial_port i_scp_serial_port (.i_sys_clk, .i_rst_n, .i_spi_clk,
    .i_spi_cs_n, .i_three_wire, .i_serial_in, .i_sdio_in, .o_sdio_out,
    .o_sdio_oe, .o_serial_out_pin, .o_serial_out_oe, .i_cfg_rd_addr,
    .o_cfg_rd_data, .o_cfg_wr, .o_cfg_wr_word);
  // ========
  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) if (o_cfg_wr === 1'b1) wr_cnt++;
  task chk(input logic [18:0] g, e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task look(input logic [10:0] a, input logic [7:0] e);
    @(negedge i_sys_clk) i_cfg_rd_addr = a;
    repeat (2) @(negedge i_sys_clk);
    chk(o_cfg_rd_data, e);
  endtask
  task t_wr4;
    i_scp_host.frame(1'b0, 11'h7FF, 8'hA5, 24, q);
    chk(wr_cnt, 1);
    chk(o_cfg_wr_word, {11'h7FF, 8'hA5});
    look(11'h7FF, 8'hA5);
    $display("t_wr4 done");
  endtask
  task t_rd4;
    i_scp_host.frame(1'b1, 11'h7FF, 8'h00, 24, q);
    chk(q, 8'hA5);
    chk(wr_cnt, 1);
    $display("t_rd4 done");
  endtask
  task t_rd3;
    @(negedge i_sys_clk) i_three_wire = 1'b1;
    i_scp_host.frame(1'b0, 11'h000, 8'h5A, 24, q);
    chk(wr_cnt, 2);
    i_scp_host.frame(1'b1, 11'h000, 8'h00, 24, q);
    chk(q, 8'h5A);
    $display("t_rd3 done");
  endtask
  task t_abort;
    i_scp_host.frame(1'b0, 11'h001, 8'hFF, 23, q);
    chk(wr_cnt, 2);
    look(11'h001, 8'h00);
    $display("t_abort done");
  endtask
  task conclude;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    i_rst_n = 1'b0;
    i_three_wire = 1'b0;
    i_cfg_rd_addr = 11'h000;
    repeat (8) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    look(11'h7FF, 8'h00);
    t_wr4;
    t_rd4;
    t_rd3;
    t_abort;
    conclude;
  end
endmodule
